//--- tsense_pkg.sv
// Package for the temperature sensor standby, conversion and serial readout.
// Assumes a 20 MHz system clock and a two-wire serial bus sampled on that clock.
package tsense_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CONV_TIME_US = 50_000;
  localparam int unsigned PERIOD16_US = 62_500;
  localparam int unsigned CONV_CYC_DEF = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PERIOD16_CYC_DEF = PERIOD16_US * (CLK_HZ / 1_000_000);

  // Command codes
  localparam logic [7:0] CMD_LOCAL_T = 8'h00;
  localparam logic [7:0] CMD_REMOTE_T = 8'h01;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] CMD_CFG_RD = 8'h03;
  localparam logic [7:0] CMD_RATE_RD = 8'h04;
  localparam logic [7:0] CMD_CFG_WR = 8'h09;
  localparam logic [7:0] CMD_RATE_WR = 8'h0A;
  localparam logic [7:0] CMD_SINGLE_SHOT = 8'h0F;
  localparam logic [7:0] CMD_REMOTE_F = 8'h10;
  localparam logic [7:0] CMD_LOCAL_F = 8'h11;

  // Fields and reset values
  localparam int unsigned CFG_HALT_BIT = 6;
  localparam int unsigned STATUS_BUSY_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h20;
  localparam logic [7:0] RATE_RESET = 8'h08;
  localparam logic [7:0] RATE_MAX_CODE = 8'h08;
  localparam logic [7:0] RATE_4HZ_CODE = 8'h06;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2A; // Arbitrary value
  localparam int unsigned FRAC_LSB = 5;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    P_IDLE, P_ADDR, P_CMD, P_WDATA, P_ACK, P_RDATA, P_MACK
  } bus_ph_t;

  typedef enum logic [1:0] {C_IDLE, C_CONV, C_WAIT} conv_st_t;

  // Whole state of the device
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, standby_pin_n_m, standby_pin_n_s;
    bus_ph_t ph;
    bus_ph_t after;
    logic [2:0] cnt;
    logic done;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic have_cmd;
    logic wrote;
    logic sda_oe;
    logic shot;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] loc_t, loc_f, rem_t, rem_f;
    conv_st_t cst;
    logic [31:0] tmr;
    logic one_run;
    logic busy;
    logic adc_en;
    logic upd;
  } dev_state_t;
endpackage

//--- tsense_dev.sv
// Temperature sensor device logic: serial slave, register set, standby
// control and conversion sequencing. Samples come from the analog front
// end on the same clock; scl, sda and the standby pin are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module tsense_dev #(
  parameter int unsigned CONV_CYCLES = tsense_pkg::CONV_CYC_DEF,
  parameter int unsigned PERIOD16_CYCLES = tsense_pkg::PERIOD16_CYC_DEF,
  parameter logic [6:0] SLAVE_ADDR = tsense_pkg::SLAVE_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic standby_pin_n,
  input wire logic [10:0] local_sample,
  input wire logic [10:0] remote_sample,
  output logic adc_en,
  output logic busy
);
  tsense_pkg::dev_state_t state_r;
  tsense_pkg::dev_state_t state_nxt;
  logic scl_rise, scl_fall, bus_start, bus_stop, hw_standby_pin_n, halt, ext_ok, abort;

  // Register read decode
  function automatic logic [7:0] read_mux(input tsense_pkg::dev_state_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      tsense_pkg::CMD_LOCAL_T: d = s.loc_t;
      tsense_pkg::CMD_REMOTE_T: d = s.rem_t;
      tsense_pkg::CMD_STATUS: d[tsense_pkg::STATUS_BUSY_BIT] = s.busy;
      tsense_pkg::CMD_CFG_RD: d = s.cfg;
      tsense_pkg::CMD_RATE_RD: d = s.rate;
      tsense_pkg::CMD_REMOTE_F: d = s.rem_f;
      tsense_pkg::CMD_LOCAL_F: d = s.loc_f;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // Wait from the end of one conversion to the next start, for a rate code
  function automatic logic [31:0] period_cyc(input logic [7:0] r);
    logic [7:0] c;
    c = (r > tsense_pkg::RATE_MAX_CODE) ? tsense_pkg::RATE_MAX_CODE : r;
    return PERIOD16_CYCLES << (tsense_pkg::RATE_MAX_CODE - c);
  endfunction

  // Edges and conditions from the synchronised copies
  assign scl_rise = state_r.scl_s & ~state_r.scl_p;
  assign scl_fall = ~state_r.scl_s & state_r.scl_p;
  assign bus_start = state_r.scl_s & state_r.scl_p & state_r.sda_p & ~state_r.sda_s;
  assign bus_stop = state_r.scl_s & state_r.scl_p & ~state_r.sda_p & state_r.sda_s;
  assign hw_standby_pin_n = ~state_r.standby_pin_n_s;
  assign halt = state_r.cfg[tsense_pkg::CFG_HALT_BIT];
  assign ext_ok = state_r.rate <= tsense_pkg::RATE_4HZ_CODE;
  assign abort = hw_standby_pin_n | (halt & ~state_r.one_run);

  // Next state of bus slave and converter sequencing
  always_comb begin
    state_nxt = state_r;
    state_nxt.scl_m = scl_i;
    state_nxt.scl_s = state_r.scl_m;
    state_nxt.scl_p = state_r.scl_s;
    state_nxt.sda_m = sda_i;
    state_nxt.sda_s = state_r.sda_m;
    state_nxt.sda_p = state_r.sda_s;
    state_nxt.standby_pin_n_m = standby_pin_n;
    state_nxt.standby_pin_n_s = state_r.standby_pin_n_m;
    state_nxt.shot = 1'b0;
    state_nxt.upd = 1'b0;
    // Serial slave, alive in every standby mode
    if (bus_start) begin
      state_nxt.ph = tsense_pkg::P_ADDR;
      state_nxt.cnt = 3'h0;
      state_nxt.done = 1'b0;
      state_nxt.sda_oe = 1'b0;
      state_nxt.have_cmd = 1'b0;
      state_nxt.wrote = 1'b0;
    end else if (bus_stop) begin
      // Send Byte ends here: only the single-shot code acts
      state_nxt.shot = state_r.have_cmd & ~state_r.wrote
        & (state_r.ptr == tsense_pkg::CMD_SINGLE_SHOT);
      state_nxt.ph = tsense_pkg::P_IDLE;
      state_nxt.sda_oe = 1'b0;
      state_nxt.have_cmd = 1'b0;
    end else if (scl_rise) begin
      case (state_r.ph)
        tsense_pkg::P_ADDR, tsense_pkg::P_CMD, tsense_pkg::P_WDATA, tsense_pkg::P_RDATA: begin
          if (state_r.ph != tsense_pkg::P_RDATA) begin
            state_nxt.sh = {state_r.sh[6:0], state_r.sda_s};
          end
          state_nxt.cnt = state_r.cnt + 3'h1;
          state_nxt.done = (state_r.cnt == tsense_pkg::LAST_BIT);
        end
        tsense_pkg::P_MACK: begin
          state_nxt.ph = state_r.sda_s ? tsense_pkg::P_IDLE : tsense_pkg::P_ACK;
          state_nxt.after = tsense_pkg::P_RDATA;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      if (state_r.done) begin
        state_nxt.done = 1'b0;
        state_nxt.cnt = 3'h0;
        case (state_r.ph)
          tsense_pkg::P_ADDR: begin
            if (state_r.sh[7:1] == SLAVE_ADDR) begin
              state_nxt.sda_oe = 1'b1;
              state_nxt.ph = tsense_pkg::P_ACK;
              state_nxt.after = state_r.sh[0] ? tsense_pkg::P_RDATA : tsense_pkg::P_CMD;
            end else begin
              state_nxt.ph = tsense_pkg::P_IDLE;
            end
          end
          tsense_pkg::P_CMD: begin
            state_nxt.ptr = state_r.sh;
            state_nxt.have_cmd = 1'b1;
            state_nxt.sda_oe = 1'b1;
            state_nxt.ph = tsense_pkg::P_ACK;
            state_nxt.after = tsense_pkg::P_WDATA;
          end
          tsense_pkg::P_WDATA: begin
            // Write Byte: only configuration and rate are writable
            if (state_r.ptr == tsense_pkg::CMD_CFG_WR) begin
              state_nxt.cfg = state_r.sh;
            end
            if (state_r.ptr == tsense_pkg::CMD_RATE_WR) begin
              state_nxt.rate = state_r.sh;
            end
            state_nxt.wrote = 1'b1;
            state_nxt.sda_oe = 1'b1;
            state_nxt.ph = tsense_pkg::P_ACK;
            state_nxt.after = tsense_pkg::P_IDLE;
          end
          tsense_pkg::P_RDATA: begin
            state_nxt.sda_oe = 1'b0;
            state_nxt.ph = tsense_pkg::P_MACK;
          end
          default: state_nxt.ph = tsense_pkg::P_IDLE;
        endcase
      end else if (state_r.ph == tsense_pkg::P_ACK) begin
        state_nxt.cnt = 3'h0;
        state_nxt.ph = state_r.after;
        state_nxt.sda_oe = 1'b0;
        if (state_r.after == tsense_pkg::P_RDATA) begin
          // Read Byte or Receive Byte: pointer selects the data
          state_nxt.sh = read_mux(state_r, state_r.ptr);
          state_nxt.sda_oe = ~state_nxt.sh[7];
        end
      end else if (state_r.ph == tsense_pkg::P_RDATA) begin
        state_nxt.sh = {state_r.sh[6:0], 1'b0};
        state_nxt.sda_oe = ~state_r.sh[6];
      end
    end
    // Conversion sequencing
    case (state_r.cst)
      tsense_pkg::C_IDLE: begin
        if (!hw_standby_pin_n && !halt) begin
          state_nxt.cst = tsense_pkg::C_CONV;
          state_nxt.tmr = CONV_CYCLES;
        end else if (state_r.shot && halt && !hw_standby_pin_n) begin
          state_nxt.cst = tsense_pkg::C_CONV;
          state_nxt.tmr = CONV_CYCLES;
          state_nxt.one_run = 1'b1;
        end
      end
      tsense_pkg::C_CONV: begin
        if (abort) begin
          state_nxt.cst = tsense_pkg::C_IDLE;
          state_nxt.one_run = 1'b0;
        end else if (state_r.tmr <= 32'h1) begin
          // Both channels and their fractions from one result
          state_nxt.loc_t = local_sample[10:3];
          state_nxt.rem_t = remote_sample[10:3];
          state_nxt.loc_f = ext_ok ? {local_sample[2:0], 5'h00} : 8'h00;
          state_nxt.rem_f = ext_ok ? {remote_sample[2:0], 5'h00} : 8'h00;
          state_nxt.upd = 1'b1;
          state_nxt.one_run = 1'b0;
          state_nxt.cst = halt ? tsense_pkg::C_IDLE : tsense_pkg::C_WAIT;
          state_nxt.tmr = period_cyc(state_r.rate);
        end else begin
          state_nxt.tmr = state_r.tmr - 32'h1;
        end
      end
      tsense_pkg::C_WAIT: begin
        if (hw_standby_pin_n || halt) begin
          state_nxt.cst = tsense_pkg::C_IDLE;
        end else if (state_r.tmr <= 32'h1) begin
          state_nxt.cst = tsense_pkg::C_CONV;
          state_nxt.tmr = CONV_CYCLES;
        end else begin
          state_nxt.tmr = state_r.tmr - 32'h1;
        end
      end
      default: state_nxt.cst = tsense_pkg::C_IDLE;
    endcase
    state_nxt.busy = (state_nxt.cst == tsense_pkg::C_CONV);
    state_nxt.adc_en = (state_nxt.cst == tsense_pkg::C_CONV);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '0;
      state_r.scl_m <= 1'b1;
      state_r.scl_s <= 1'b1;
      state_r.scl_p <= 1'b1;
      state_r.sda_m <= 1'b1;
      state_r.sda_s <= 1'b1;
      state_r.sda_p <= 1'b1;
      state_r.standby_pin_n_m <= 1'b1;
      state_r.standby_pin_n_s <= 1'b1;
      state_r.ph <= tsense_pkg::P_IDLE;
      state_r.after <= tsense_pkg::P_IDLE;
      state_r.cfg <= tsense_pkg::CFG_RESET;
      state_r.rate <= tsense_pkg::RATE_RESET;
      state_r.loc_t <= tsense_pkg::TEMP_RESET;
      state_r.rem_t <= tsense_pkg::TEMP_RESET;
      state_r.loc_f <= tsense_pkg::TEMP_RESET;
      state_r.rem_f <= tsense_pkg::TEMP_RESET;
      state_r.cst <= tsense_pkg::C_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register, except sda_o, which is tied low
  assign sda_o = 1'b0;
  assign sda_oe = state_r.sda_oe;
  assign adc_en = state_r.adc_en;
  assign busy = state_r.busy;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hw_standby_pin_n_off: assert property (hw_standby_pin_n |=> !adc_en)
    else $error("converter on in hardware standby");
  a_halt_abort: assert property ($rose(halt) && state_r.cst == tsense_pkg::C_CONV && !state_r.one_run
    |=> state_r.cst == tsense_pkg::C_IDLE && !busy)
    else $error("software standby did not abort conversion");
  a_abort_keeps: assert property (state_r.cst == tsense_pkg::C_CONV && abort
    |=> $stable(state_r.loc_t) && $stable(state_r.rem_t) && $stable(state_r.loc_f))
    else $error("aborted conversion changed results");
  a_update_pair: assert property (state_r.upd |-> state_r.loc_t == $past(local_sample[10:3])
    && state_r.rem_t == $past(remote_sample[10:3]))
    else $error("main registers not from same result");
  a_frac_slow: assert property (state_r.upd && $past(ext_ok)
    |-> state_r.loc_f[7:5] == $past(local_sample[2:0]) && state_r.rem_f[4:0] == 5'h00)
    else $error("fraction bits misplaced");
  a_frac_fast: assert property (state_r.upd && !$past(ext_ok)
    |-> state_r.loc_f == 8'h00 && state_r.rem_f == 8'h00)
    else $error("fraction written at fast rate");
  a_shot_start: assert property (state_r.shot && halt && !hw_standby_pin_n
    && state_r.cst == tsense_pkg::C_IDLE |=> busy ##1 adc_en)
    else $error("single-shot did not start conversion");
  a_free_run: assert property (!halt && !hw_standby_pin_n && state_r.cst == tsense_pkg::C_IDLE
    |=> busy && adc_en)
    else $error("free-running conversion not started");
  a_stop_release: assert property (bus_stop |=> !sda_oe && state_r.ph == tsense_pkg::P_IDLE)
    else $error("bus not released at stop");
  a_addr_nack: assert property (scl_fall && state_r.done && state_r.ph == tsense_pkg::P_ADDR
    && state_r.sh[7:1] != SLAVE_ADDR |=> !sda_oe [*2])
    else $error("foreign address acknowledged");

  c_shot: cover property (state_r.shot ##1 state_r.one_run);
  c_abort: cover property (state_r.cst == tsense_pkg::C_CONV && abort);
  c_read: cover property (state_r.ph == tsense_pkg::P_MACK);
  c_cfg_write: cover property ($rose(halt));
endmodule
`default_nettype wire

//--- tsense_host.sv
// Host model of the two-wire management bus: drives the bus clock, pulls data low.
// Assumes a pull-up on the data line and the bench clock as its timebase.
`timescale 1ns/1ns
`default_nettype none
module tsense_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_pull
);
  logic [6:0] addr;
  logic nak;
  // Idle bus, both lines released; bus clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
    addr = tsense_pkg::SLAVE_ADDR_DEF;
    nak = 1'b0;
  end
  // Quarter of a 400 ns bus period, changes just after an edge
  task automatic cyc();
    repeat (2) @(posedge clk);
    #2;
  endtask
  // Start, or repeated start from a low bus clock
  task automatic start();
    sda_pull = 1'b0;
    cyc();
    scl_o = 1'b1;
    cyc();
    sda_pull = 1'b1;
    cyc();
    scl_o = 1'b0;
    cyc();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    cyc();
    scl_o = 1'b1;
    cyc();
    sda_pull = 1'b0;
    cyc();
  endtask
  // One bit: data set while clock low, line taken at end of high phase
  task automatic bit_x(input logic b, output logic r);
    sda_pull = ~b;
    cyc();
    scl_o = 1'b1;
    cyc();
    cyc();
    r = sda_line;
    scl_o = 1'b0;
    cyc();
  endtask
  // Byte out, most significant bit first, then slave acknowledge
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    nak = nak | r;
  endtask
  // Byte in, most significant bit first, then master nack
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(1'b1, r);
  endtask
  // Write Byte, Read Byte, Send Byte, Receive Byte
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    start();
    put({addr, 1'b0});
    put(c);
    put(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    start();
    put({addr, 1'b0});
    put(c);
    start();
    put({addr, 1'b1});
    get(d);
    stop();
  endtask
  task automatic snd(input logic [7:0] c);
    start();
    put({addr, 1'b0});
    put(c);
    stop();
  endtask
  task automatic rcv(output logic [7:0] d);
    start();
    put({addr, 1'b1});
    get(d);
    stop();
  endtask
endmodule
`default_nettype wire

//--- temp_sensor_standby_and_readout_tb.sv
// Self-checking bench for the temperature sensor standby and readout logic.
// Assumes tsense_pkg, tsense_dev and the host model tsense_host.
`timescale 1ns/1ns
`default_nettype none
module temp_sensor_standby_and_readout_tb;
  logic clk, rst, standby_pin_n, sda_pull, scl, sda_o, sda_oe, adc_en, busy, sda_line, s;
  logic [10:0] local_sample, remote_sample;
  logic [7:0] v, m_cfg, m_lt, m_lf, m_rt, m_rf;
  int miscompares, checked, m_rate;
  // Open-drain data line with pull-up
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
  tsense_dev #(.CONV_CYCLES(40), .PERIOD16_CYCLES(60),
    .SLAVE_ADDR(tsense_pkg::SLAVE_ADDR_DEF)) i_dut (.clk(clk), .rst(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .standby_pin_n(standby_pin_n),
    .local_sample(local_sample), .remote_sample(remote_sample), .adc_en(adc_en), .busy(busy));
  tsense_host i_host (.clk(clk), .sda_line(sda_line), .scl_o(scl), .sda_pull(sda_pull));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait for the busy output to reach a level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 3000) begin
      @(posedge clk);
      #2;
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      summarize();
    end
  endtask
  // Watch for any converter activity over 300 cycles
  task automatic quiet();
    s = 1'b0;
    repeat (300) begin
      @(posedge clk);
      #2;
      s = s | adc_en | busy;
    end
    check({7'h00, s}, 8'h00);
  endtask
  // Model of one completed conversion
  task automatic model_conv();
    m_lt = local_sample[10:3];
    m_rt = remote_sample[10:3];
    m_lf = (m_rate <= 6) ? {local_sample[2:0], 5'h00} : 8'h00;
    m_rf = (m_rate <= 6) ? {remote_sample[2:0], 5'h00} : 8'h00;
  endtask
  task automatic new_samples();
    local_sample = 11'($urandom);
    remote_sample = 11'($urandom);
  endtask
  task automatic read_temps();
    i_host.rd(tsense_pkg::CMD_LOCAL_T, v);
    check(v, m_lt);
    i_host.rd(tsense_pkg::CMD_REMOTE_T, v);
    check(v, m_rt);
    i_host.rd(tsense_pkg::CMD_REMOTE_F, v);
    check(v, m_rf);
    i_host.rd(tsense_pkg::CMD_LOCAL_F, v);
    check(v, m_lf);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    standby_pin_n = 1'b1;
    miscompares = 0;
    checked = 0;
    m_cfg = 8'h20;
    m_rate = 8;
    local_sample = 11'($urandom(57182));
    remote_sample = 11'($urandom);
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    model_conv();
    repeat (200) @(posedge clk);
    #2;
    i_host.rd(tsense_pkg::CMD_CFG_RD, v);
    check(v, m_cfg);
    i_host.rd(tsense_pkg::CMD_RATE_RD, v);
    check(v, 8'h08);
    read_temps();
    $display("test reset_free_run done");
    m_cfg = 8'h40;
    i_host.wr(tsense_pkg::CMD_CFG_WR, m_cfg);
    m_rate = 6;
    i_host.wr(tsense_pkg::CMD_RATE_WR, 8'h06);
    quiet();
    new_samples();
    read_temps();
    i_host.snd(tsense_pkg::CMD_SINGLE_SHOT);
    wait_busy(1'b1);
    wait_busy(1'b0);
    model_conv();
    i_host.rd(tsense_pkg::CMD_STATUS, v);
    check(v & 8'h80, 8'h00);
    read_temps();
    i_host.rcv(v);
    check(v, m_lf);
    i_host.snd(tsense_pkg::CMD_CFG_WR);
    i_host.rd(tsense_pkg::CMD_CFG_RD, v);
    check(v, m_cfg);
    check({7'h00, i_host.nak}, 8'h00);
    $display("test soft_standby_shot done");
    standby_pin_n = 1'b0;
    new_samples();
    i_host.snd(tsense_pkg::CMD_SINGLE_SHOT);
    quiet();
    read_temps();
    i_host.wr(tsense_pkg::CMD_LOCAL_T, 8'h5A);
    i_host.rd(tsense_pkg::CMD_LOCAL_T, v);
    check(v, m_lt);
    i_host.rd(8'h05, v);
    check(v, 8'h00);
    i_host.addr = tsense_pkg::SLAVE_ADDR_DEF ^ 7'h01;
    i_host.rd(tsense_pkg::CMD_CFG_RD, v);
    check({7'h00, i_host.nak}, 8'h01);
    i_host.addr = tsense_pkg::SLAVE_ADDR_DEF;
    i_host.nak = 1'b0;
    $display("test hard_standby done");
    standby_pin_n = 1'b1;
    i_host.snd(tsense_pkg::CMD_SINGLE_SHOT);
    wait_busy(1'b1);
    standby_pin_n = 1'b0;
    wait_busy(1'b0);
    standby_pin_n = 1'b1;
    read_temps();
    $display("test abort done");
    m_cfg = 8'h00;
    i_host.wr(tsense_pkg::CMD_CFG_WR, m_cfg);
    wait_busy(1'b1);
    check({7'h00, adc_en}, 8'h01);
    model_conv();
    v = 8'h80;
    for (int n = 0; n < 8 && v[7] !== 1'b0; n++) begin
      i_host.rd(tsense_pkg::CMD_STATUS, v);
    end
    check(v & 8'h80, 8'h00);
    read_temps();
    $display("test free_run_poll done");
    // Halt written while a free-running conversion is in progress
    m_rate = 8;
    i_host.wr(tsense_pkg::CMD_RATE_WR, 8'h08);
    wait_busy(1'b1);
    wait_busy(1'b0);
    model_conv();
    wait_busy(1'b1);
    m_cfg = 8'h40;
    i_host.wr(tsense_pkg::CMD_CFG_WR, m_cfg);
    quiet();
    read_temps();
    check({7'h00, i_host.nak}, 8'h00);
    $display("test halt_abort done");
    summarize();
  end
endmodule
`default_nettype wire
